// ---- verilog/vta_pkg.sv ----
package vta_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int BAUD_RATE = 4800;
  localparam int BAUD_DIV = CLK_HZ / BAUD_RATE;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  // time of day in ms
  localparam logic [26:0] DAY_MS = 27'h5265C00;
  localparam logic [26:0] HOUR_MS = 27'h036EE80;
  localparam logic [26:0] MIN_MS = 27'h000EA60;
  localparam logic [26:0] SEC_MS = 27'h00003E8;
  localparam logic [3:0] OFFSET_BASE = 4'hC;
  // pin synchroniser reset: rx, pps, run, event, crosshair
  localparam logic [4:0] SYNC_RST = 5'h17;
  // sentence and command characters
  localparam logic [7:0] CH_START = 8'h24;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_VALID = 8'h41;
  localparam logic [47:0] RMC_TAG = 48'h4750524D432C;
  localparam logic [3:0] FLD_TIME = 4'h1;
  localparam logic [3:0] FLD_STATUS = 4'h2;
  localparam logic [3:0] FLD_DATE = 4'h9;
  localparam logic [7:0] CMD_READ = 8'h52;
  localparam logic [7:0] CMD_WRITE = 8'h57;
  localparam logic [7:0] CMD_UP = 8'h75;
  localparam logic [7:0] CMD_DOWN = 8'h64;
  localparam logic [7:0] CMD_LEFT = 8'h6C;
  localparam logic [7:0] CMD_RIGHT = 8'h72;
  // serial report
  localparam logic [7:0] REP_EVT_HDR = 8'h45;
  localparam logic [7:0] REP_READ_HDR = 8'h44;
  localparam logic [3:0] REP_LAST = 4'h9;
  // crosshair
  localparam logic [9:0] XH_X_CENTER = 10'h168;
  localparam logic [8:0] XH_Y_CENTER = 9'h0F0;
  localparam logic [9:0] XH_X_MAX = 10'h2CF;
  localparam logic [8:0] XH_Y_MAX = 9'h1DF;
  typedef enum logic [2:0] {
    XH_OFF = 3'b001,
    XH_WHITE = 3'b010,
    XH_BLACK = 3'b100
  } xhair_e;
  typedef enum logic [2:0] {
    P_IDLE = 3'b001,
    P_TAG = 3'b010,
    P_FIELDS = 3'b100
  } parse_e;
endpackage : vta_pkg

// ---- verilog/byte_if.sv ----
`timescale 1ns/1ps
interface byte_if ();
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_if

// ---- verilog/uart_tx.sv ----
`timescale 1ns/1ps
module uart_tx #(
  parameter int DIV = vta_pkg::BAUD_DIV
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  byte_if.snk bus,
  output logic o_tx
);
  localparam int DW = $clog2(DIV);
  logic [DW-1:0] div_reg;
  logic [9:0] sh_reg;
  logic [3:0] left_reg;

  assign bus.ready = (left_reg == 4'h0);
  assign o_tx = sh_reg[0];

  // start bit, eight data bits lsb first, one stop bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_reg <= 10'h3FF;
      left_reg <= 4'h0;
      div_reg <= '0;
    end else if (left_reg == 4'h0) begin
      if (bus.valid) begin
        sh_reg <= {1'b1, bus.data, 1'b0};
        left_reg <= 4'hA;
        div_reg <= '0;
      end
    end else if (div_reg == DW'(DIV - 1)) begin
      div_reg <= '0;
      sh_reg <= {1'b1, sh_reg[9:1]};
      left_reg <= left_reg - 4'h1;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
endmodule : uart_tx

// ---- verilog/uart_rx.sv ----
`timescale 1ns/1ps
module uart_rx #(
  parameter int DIV = vta_pkg::BAUD_DIV
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rx,
  byte_if.src bus
);
  localparam int DW = $clog2(DIV);
  logic [DW-1:0] div_reg;
  logic [8:0] sh_reg;
  logic [3:0] bit_reg;
  logic busy_reg;
  logic valid_reg;

  assign bus.data = sh_reg[7:0];
  assign bus.valid = valid_reg;

  // first sample lands mid start bit, then one per bit time
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= '0;
      sh_reg <= '0;
      bit_reg <= 4'h0;
      busy_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (!busy_reg) begin
        if (!i_rx) begin
          busy_reg <= 1'b1;
          div_reg <= DW'(DIV / 2);
          bit_reg <= 4'h0;
        end
      end else if (div_reg == DW'(DIV - 1)) begin
        div_reg <= '0;
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'h0) begin
          busy_reg <= ~i_rx;
        end else begin
          sh_reg <= {i_rx, sh_reg[8:1]};
        end
        if (bit_reg == 4'h9) begin
          busy_reg <= 1'b0;
          valid_reg <= i_rx;
        end
      end else begin
        div_reg <= div_reg + 1'b1;
      end
    end
  end
endmodule : uart_rx

// ---- verilog/video_time_event_annotator.sv ----
`timescale 1ns/1ps
// How it works
// - time latched at vsync, frame or field
// - shown time is reference plus hour offset
// - range switch picks -12..+3 or +12..-3
// - count from zero, flag once reference seen
// - time free-runs through reference dropouts
// - run/event edges count and latch time
// - run activation clears the event count
// - counts and time shown, marked, sent
// - captures ignored until report finishes
// - serial 4800 baud, 8N1, no handshake
// - lat/long shown only when switch on with GPS reference
// - edge marking follows its switch outside read mode
// - computer commands enter read mode
// - annotation picks top and bottom text
// - crosshair cycles white, black, off
// - crosshair moves in read mode only
// - GPS or timecode, free-run fallback
module video_time_event_annotator #(
  parameter int MS_CYCLES = vta_pkg::MS_CYCLES,
  parameter int BAUD_DIV = vta_pkg::BAUD_DIV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // serial link and pulse per second
  input wire logic i_ser_rx,
  output logic o_ser_tx,
  input wire logic i_pps,
  // contact inputs, active low
  input wire logic i_run_n,
  input wire logic i_event_n,
  input wire logic i_xhair_n,
  // switches
  input wire logic i_sw_offset_neg,
  input wire logic i_sw_frame,
  input wire logic i_sw_latlon,
  input wire logic i_sw_edge,
  input wire logic [3:0] i_hour_sel,
  input wire logic i_ref_irig,
  input wire logic i_annot_en,
  input wire logic i_user_bottom,
  // timecode decoder and video timing
  input wire logic i_irig_load,
  input wire logic [26:0] i_irig_ms,
  input wire logic i_vsync,
  input wire logic i_field_odd,
  input wire logic i_edge_word_valid,
  input wire logic [31:0] i_edge_word,
  // display and status
  output logic [26:0] o_disp_ms,
  output logic [23:0] o_disp_date,
  output logic o_sync_ok,
  output logic o_latlon_on,
  output logic o_top_gps,
  output logic o_top_user,
  output logic o_bottom_user,
  output logic o_edge_write,
  output logic o_read_mode,
  output logic o_armed,
  output logic o_capture_shown,
  output logic [15:0] o_run_count,
  output logic [15:0] o_event_count,
  output logic [26:0] o_event_ms,
  output logic o_xhair_white,
  output logic o_xhair_black,
  output logic [9:0] o_xhair_x,
  output logic [8:0] o_xhair_y
);
  localparam int MW = $clog2(MS_CYCLES);

  function automatic logic [26:0] wrap_day(input logic [27:0] v);
    wrap_day = (v >= {1'b0, vta_pkg::DAY_MS}) ? 27'(v - {1'b0, vta_pkg::DAY_MS})
                                               : v[26:0];
  endfunction : wrap_day

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= 8'h30) && (c <= 8'h39);
  endfunction : is_digit

  function automatic logic [26:0] bcd2(input logic [7:0] b, input logic [26:0] unit);
    bcd2 = (27'(b[7:4]) * 27'hA + 27'(b[3:0])) * unit;
  endfunction : bcd2

  logic [4:0] pin_raw;
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [4:0] prev_reg;
  assign pin_raw = {i_ser_rx, i_pps, i_run_n, i_event_n, i_xhair_n};
  for (genvar g = 0; g < 5; g++) begin : g_sync
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        meta_reg[g] <= vta_pkg::SYNC_RST[g];
        sync_reg[g] <= vta_pkg::SYNC_RST[g];
        prev_reg[g] <= vta_pkg::SYNC_RST[g];
      end else begin
        meta_reg[g] <= pin_raw[g];
        sync_reg[g] <= meta_reg[g];
        prev_reg[g] <= sync_reg[g];
      end
    end
  end

  logic pps_rise;
  logic run_fall;
  logic event_fall;
  logic xh_fall;
  assign pps_rise = sync_reg[3] & ~prev_reg[3];
  assign run_fall = prev_reg[2] & ~sync_reg[2];
  assign event_fall = prev_reg[1] & ~sync_reg[1];
  assign xh_fall = prev_reg[0] & ~sync_reg[0];

  // serial ports
  byte_if rx_bus ();
  byte_if tx_bus ();
  // 8N1 at the package baud rate
  uart_rx #(.DIV(BAUD_DIV)) u_rx (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_rx(sync_reg[4]),
    .bus(rx_bus.src)
  );
  uart_tx #(.DIV(BAUD_DIV)) u_tx (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(tx_bus.snk),
    .o_tx(o_ser_tx)
  );
  assign rx_bus.ready = 1'b1;

  // sentence parser state
  vta_pkg::parse_e pstate_reg;
  logic [47:0] tag_reg;
  logic [3:0] field_reg;
  logic [23:0] tbcd_reg;
  logic [23:0] dbcd_reg;
  logic [23:0] date_reg;
  logic [7:0] status_reg;
  logic [26:0] gps_ms_reg;
  logic gps_ok_reg;
  logic [7:0] rxc;
  logic rxv;
  logic sent_end;
  assign rxc = rx_bus.data;
  assign rxv = rx_bus.valid;
  assign sent_end = rxv && pstate_reg == vta_pkg::P_FIELDS
                    && (rxc == vta_pkg::CH_STAR || rxc == vta_pkg::CH_CR);

  // time base
  logic [MW-1:0] ms_div_reg;
  logic [26:0] ms_cnt;
  logic [26:0] local_reg;
  logic ms_tick;
  logic gps_align;
  logic irig_align;
  assign ms_tick = ms_div_reg == MW'(MS_CYCLES - 1);
  // pulse edge with a fresh sentence aligns time
  assign gps_align = pps_rise & ~i_ref_irig & gps_ok_reg;
  assign irig_align = i_irig_load & i_ref_irig;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms_div_reg <= '0;
    end else if (gps_align || irig_align || ms_tick) begin
      ms_div_reg <= '0;
    end else begin
      ms_div_reg <= ms_div_reg + 1'b1;
    end
  end

  // starts at zero; keeps counting without a reference
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms_cnt <= '0;
    end else if (irig_align) begin
      ms_cnt <= i_irig_ms;
    end else if (gps_align) begin
      // sentence names the previous pulse, so add a second
      ms_cnt <= wrap_day({1'b0, gps_ms_reg} + {1'b0, vta_pkg::SEC_MS});
    end else if (ms_tick) begin
      ms_cnt <= wrap_day({1'b0, ms_cnt} + 28'h1);
    end
  end

  // flag stays up, time free-runs if the reference is lost
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sync_ok <= 1'b0;
    end else if (gps_align || irig_align) begin
      o_sync_ok <= 1'b1;
    end
  end

  // offset sign and range from the switch
  logic [3:0] off_mag;
  logic off_neg;
  logic [26:0] off_ms;
  always_comb begin
    if (i_sw_offset_neg) begin
      off_neg = i_hour_sel < vta_pkg::OFFSET_BASE;
      off_mag = off_neg ? vta_pkg::OFFSET_BASE - i_hour_sel
                        : i_hour_sel - vta_pkg::OFFSET_BASE;
    end else begin
      off_neg = i_hour_sel > vta_pkg::OFFSET_BASE;
      off_mag = off_neg ? i_hour_sel - vta_pkg::OFFSET_BASE
                        : vta_pkg::OFFSET_BASE - i_hour_sel;
    end
    off_ms = 27'(off_mag) * vta_pkg::HOUR_MS;
  end

  // local time is reference time plus the offset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      local_reg <= '0;
    end else if (off_neg) begin
      local_reg <= wrap_day({1'b0, ms_cnt} + {1'b0, vta_pkg::DAY_MS} - {1'b0, off_ms});
    end else begin
      local_reg <= wrap_day({1'b0, ms_cnt} + {1'b0, off_ms});
    end
  end

  // latch at vsync; frame mode skips the second field
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_disp_ms <= '0;
      o_disp_date <= '0;
    end else if (i_vsync && !(i_sw_frame && i_field_odd)) begin
      o_disp_ms <= local_reg;
      o_disp_date <= date_reg;
    end
  end

  // RMC sentence: time, status and date fields
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pstate_reg <= vta_pkg::P_IDLE;
      tag_reg <= '0;
      field_reg <= 4'h0;
      tbcd_reg <= '0;
      dbcd_reg <= '0;
      status_reg <= '0;
    end else if (rxv) begin
      case (pstate_reg)
        vta_pkg::P_IDLE: begin
          if (rxc == vta_pkg::CH_START) begin
            pstate_reg <= vta_pkg::P_TAG;
            tag_reg <= vta_pkg::RMC_TAG;
          end
        end
        vta_pkg::P_TAG: begin
          if (rxc != tag_reg[47:40]) begin
            pstate_reg <= vta_pkg::P_IDLE;
          end else if (tag_reg[39:0] == 40'h0) begin
            pstate_reg <= vta_pkg::P_FIELDS;
            field_reg <= vta_pkg::FLD_TIME;
            status_reg <= '0;
          end else begin
            tag_reg <= {tag_reg[39:0], 8'h00};
          end
        end
        vta_pkg::P_FIELDS: begin
          if (sent_end || rxc == vta_pkg::CH_START) begin
            pstate_reg <= vta_pkg::P_IDLE;
          end else if (rxc == vta_pkg::CH_COMMA) begin
            field_reg <= field_reg + 4'h1;
          end else if (field_reg == vta_pkg::FLD_STATUS) begin
            status_reg <= rxc;
          end else if (is_digit(rxc) && field_reg == vta_pkg::FLD_TIME) begin
            tbcd_reg <= {tbcd_reg[19:0], rxc[3:0]};
          end else if (is_digit(rxc) && field_reg == vta_pkg::FLD_DATE) begin
            dbcd_reg <= {dbcd_reg[19:0], rxc[3:0]};
          end
        end
        default: pstate_reg <= vta_pkg::P_IDLE;
      endcase
    end
  end

  // fraction digits shift through, so only the last six digits of the field are used
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gps_ok_reg <= 1'b0;
      gps_ms_reg <= '0;
      date_reg <= '0;
    end else if (sent_end && status_reg == vta_pkg::CH_VALID) begin
      gps_ok_reg <= 1'b1;
      gps_ms_reg <= bcd2(tbcd_reg[23:16], vta_pkg::HOUR_MS)
                    + bcd2(tbcd_reg[15:8], vta_pkg::MIN_MS)
                    + bcd2(tbcd_reg[7:0], vta_pkg::SEC_MS);
      date_reg <= dbcd_reg;
    end else if (gps_align) begin
      gps_ok_reg <= 1'b0;
    end
  end

  // commands outside sentences; moves only in read mode
  logic cmd_v;
  assign cmd_v = rxv && pstate_reg == vta_pkg::P_IDLE;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_read_mode <= 1'b0;
      o_xhair_x <= vta_pkg::XH_X_CENTER;
      o_xhair_y <= vta_pkg::XH_Y_CENTER;
    end else if (cmd_v) begin
      if (rxc == vta_pkg::CMD_READ) begin
        o_read_mode <= 1'b1;
      end else if (rxc == vta_pkg::CMD_WRITE) begin
        o_read_mode <= 1'b0;
      end else if (o_read_mode) begin
        if (rxc == vta_pkg::CMD_UP && o_xhair_y != 9'h0) begin
          o_xhair_y <= o_xhair_y - 9'h1;
        end else if (rxc == vta_pkg::CMD_DOWN && o_xhair_y != vta_pkg::XH_Y_MAX) begin
          o_xhair_y <= o_xhair_y + 9'h1;
        end else if (rxc == vta_pkg::CMD_LEFT && o_xhair_x != 10'h0) begin
          o_xhair_x <= o_xhair_x - 10'h1;
        end else if (rxc == vta_pkg::CMD_RIGHT && o_xhair_x != vta_pkg::XH_X_MAX) begin
          o_xhair_x <= o_xhair_x + 10'h1;
        end
      end
    end
  end

  vta_pkg::xhair_e xh_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xh_reg <= vta_pkg::XH_OFF;
    end else if (xh_fall) begin
      case (xh_reg)
        vta_pkg::XH_OFF: xh_reg <= vta_pkg::XH_WHITE;
        vta_pkg::XH_WHITE: xh_reg <= vta_pkg::XH_BLACK;
        default: xh_reg <= vta_pkg::XH_OFF;
      endcase
    end
  end
  assign o_xhair_white = xh_reg == vta_pkg::XH_WHITE;
  assign o_xhair_black = xh_reg == vta_pkg::XH_BLACK;

  // capture and report
  logic rep_busy_reg;
  logic rep_kind_reg;
  logic [3:0] rep_idx_reg;
  logic [31:0] rd_word_reg;
  logic [9:0] rd_x_reg;
  logic [8:0] rd_y_reg;
  logic cap_go;
  logic rd_go;
  // edges while disarmed or sending are dropped
  assign cap_go = o_armed & ~rep_busy_reg & (run_fall | event_fall);
  assign rd_go = ~cap_go & ~rep_busy_reg & o_read_mode & i_edge_word_valid;

  // counts and time latch; run clears events
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_run_count <= '0;
      o_event_count <= '0;
      o_event_ms <= '0;
      o_capture_shown <= 1'b0;
    end else if (cap_go) begin
      o_event_ms <= local_reg;
      o_capture_shown <= 1'b1;
      if (run_fall) begin
        o_run_count <= o_run_count + 16'h1;
        o_event_count <= '0;
      end else begin
        o_event_count <= o_event_count + 16'h1;
      end
    end
  end

  // report goes out over serial; read data likewise
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rep_busy_reg <= 1'b0;
      rep_kind_reg <= 1'b0;
      rep_idx_reg <= 4'h0;
      rd_word_reg <= '0;
      rd_x_reg <= '0;
      rd_y_reg <= '0;
    end else if (cap_go || rd_go) begin
      rep_busy_reg <= 1'b1;
      rep_kind_reg <= rd_go;
      rep_idx_reg <= 4'h0;
      if (rd_go) begin
        rd_word_reg <= i_edge_word;
        rd_x_reg <= o_xhair_x;
        rd_y_reg <= o_xhair_y;
      end
    end else if (rep_busy_reg && tx_bus.ready) begin
      rep_busy_reg <= rep_idx_reg != vta_pkg::REP_LAST;
      rep_idx_reg <= rep_idx_reg + 4'h1;
    end
  end

  // re-arm only once the last byte has left the line
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_armed <= 1'b1;
    end else if (cap_go) begin
      o_armed <= 1'b0;
    end else if (!rep_busy_reg && tx_bus.ready) begin
      o_armed <= 1'b1;
    end
  end

  logic [7:0] rep_byte;
  always_comb begin
    rep_byte = vta_pkg::CH_CR;
    case (rep_idx_reg)
      4'h0: rep_byte = rep_kind_reg ? vta_pkg::REP_READ_HDR : vta_pkg::REP_EVT_HDR;
      4'h1: rep_byte = rep_kind_reg ? rd_word_reg[31:24] : o_run_count[15:8];
      4'h2: rep_byte = rep_kind_reg ? rd_word_reg[23:16] : o_run_count[7:0];
      4'h3: rep_byte = rep_kind_reg ? rd_word_reg[15:8] : o_event_count[15:8];
      4'h4: rep_byte = rep_kind_reg ? rd_word_reg[7:0] : o_event_count[7:0];
      4'h5: rep_byte = rep_kind_reg ? {6'h0, rd_x_reg[9:8]} : {5'h0, o_event_ms[26:24]};
      4'h6: rep_byte = rep_kind_reg ? rd_x_reg[7:0] : o_event_ms[23:16];
      4'h7: rep_byte = rep_kind_reg ? {7'h0, rd_y_reg[8]} : o_event_ms[15:8];
      4'h8: rep_byte = rep_kind_reg ? rd_y_reg[7:0] : o_event_ms[7:0];
      default: rep_byte = vta_pkg::CH_CR;
    endcase
  end
  assign tx_bus.valid = rep_busy_reg;
  assign tx_bus.data = rep_byte;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_latlon_on <= 1'b0;
      o_edge_write <= 1'b0;
      o_top_gps <= 1'b0;
      o_top_user <= 1'b0;
      o_bottom_user <= 1'b0;
    end else begin
      o_latlon_on <= i_sw_latlon & ~i_ref_irig;
      o_edge_write <= i_sw_edge & ~o_read_mode;
      o_top_gps <= i_annot_en & ~i_ref_irig;
      o_top_user <= i_annot_en & i_ref_irig;
      o_bottom_user <= i_annot_en & i_user_bottom;
    end
  end

  chk_vsync_latch: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_vsync && !(i_sw_frame && i_field_odd) |=> o_disp_ms == $past(local_reg))
    else $error("display time not latched at vsync");
  chk_frame_skip: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_vsync && i_sw_frame && i_field_odd |=> $stable(o_disp_ms))
    else $error("display time changed on skipped field");
  chk_offset_range: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_sw_offset_neg && i_hour_sel == 4'h0 |=> local_reg ==
      wrap_day({1'b0, $past(ms_cnt)} + {1'b0, vta_pkg::DAY_MS} - 28'(12 * 3600000)))
    else $error("minus twelve hour offset wrong");
  chk_ms_count: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ms_tick && !gps_align && !irig_align |=> ms_cnt == wrap_day({1'b0, $past(ms_cnt)} + 28'h1))
    else $error("ms counter failed to advance");
  chk_sync_flag: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    irig_align |=> o_sync_ok && ms_cnt == $past(i_irig_ms))
    else $error("timecode load not taken");
  chk_run_clear: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    cap_go && run_fall |=> o_event_count == 16'h0
      && o_run_count == $past(o_run_count) + 16'h1 && o_event_ms == $past(local_reg))
    else $error("run capture wrong");
  chk_event_count: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    cap_go && !run_fall |=> o_event_count == $past(o_event_count) + 16'h1)
    else $error("event count not advanced");
  chk_busy_ignore: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_armed |=> $stable(o_run_count) && $stable(o_event_count))
    else $error("capture taken while disarmed");
  chk_xhair_cycle: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    xh_fall && xh_reg == vta_pkg::XH_WHITE |=> xh_reg == vta_pkg::XH_BLACK)
    else $error("crosshair did not go white to black");
  chk_xhair_hold: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_read_mode |=> $stable(o_xhair_x) && $stable(o_xhair_y))
    else $error("crosshair moved outside read mode");
  chk_edge_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> o_edge_write == ($past(i_sw_edge) && !$past(o_read_mode)))
    else $error("edge marking does not follow switch");
endmodule : video_time_event_annotator

// ---- sim/gps_model.sv ----
`timescale 1ns/1ps
module gps_model #(
  parameter int DIV = 16
) (
  input wire logic i_clk,
  output logic o_rx,
  output logic o_pps
);
  initial begin
    o_rx = 1'b1;
    o_pps = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      #1 o_rx = f[i];
      repeat (DIV - 1) @(posedge i_clk);
    end
  endtask : send_byte
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) send_byte(s[i]);
  endtask : send_str
  task automatic pulse(input int n);
    @(posedge i_clk);
    #1 o_pps = 1'b1;
    repeat (n) @(posedge i_clk);
    #1 o_pps = 1'b0;
  endtask : pulse
endmodule : gps_model

// ---- sim/video_time_event_annotator_tb.sv ----
`timescale 1ns/1ps
module video_time_event_annotator_tb;
  localparam int D = 16;
  localparam logic [26:0] H = vta_pkg::HOUR_MS;
  logic clk, rst_n, rx, pps, run_n, ev_n, xh_n, neg, frame, ll_sw, ed_sw, irig, ild, vs, odd;
  logic [3:0] sel;
  logic [26:0] ims, dms, evm;
  logic [23:0] date;
  logic [15:0] rc, ec;
  logic tx, sok, ll, ew, rm, arm, xw, xb, an, ub, tg, tu, bu, cs;
  logic [9:0] xx;
  logic [8:0] yy;
  logic [7:0] b;
  int num_errors = 0;
  int cmp_count = 0;
  gps_model #(.DIV(D)) gps_model_i (.i_clk(clk), .o_rx(rx), .o_pps(pps));
  video_time_event_annotator #(.MS_CYCLES(20), .BAUD_DIV(D)) video_time_event_annotator_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_ser_rx(rx), .o_ser_tx(tx), .i_pps(pps),
    .i_run_n(run_n), .i_event_n(ev_n), .i_xhair_n(xh_n), .i_sw_offset_neg(neg),
    .i_sw_frame(frame), .i_sw_latlon(ll_sw), .i_sw_edge(ed_sw), .i_hour_sel(sel),
    .i_ref_irig(irig), .i_annot_en(an), .i_user_bottom(ub), .i_irig_load(ild),
    .i_irig_ms(ims), .i_vsync(vs), .i_field_odd(odd), .i_edge_word_valid(1'b0),
    .i_edge_word(32'h0), .o_disp_ms(dms), .o_disp_date(date), .o_sync_ok(sok),
    .o_latlon_on(ll), .o_top_gps(tg), .o_top_user(tu), .o_bottom_user(bu), .o_edge_write(ew),
    .o_read_mode(rm), .o_armed(arm), .o_capture_shown(cs), .o_run_count(rc),
    .o_event_count(ec), .o_event_ms(evm), .o_xhair_white(xw), .o_xhair_black(xb),
    .o_xhair_x(xx), .o_xhair_y(yy));
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  function automatic logic near(input logic [26:0] v, input logic [26:0] e);
    return v >= e && v <= e + 27'h2;
  endfunction : near
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic hit(ref logic p);
    p = 1'b0;
    cyc(5);
    p = 1'b1;
    cyc(5);
  endtask : hit
  task automatic show();
    vs = 1'b1;
    cyc(1);
    vs = 1'b0;
    cyc(3);
  endtask : show
  task automatic rx_byte(output logic [7:0] v);
    int n;
    n = 0;
    while (tx === 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (D + D / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      v[i] = tx;
      repeat (D) @(posedge clk);
    end
    #1;
  endtask : rx_byte
  task automatic wait_arm();
    int n;
    n = 0;
    while (arm !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk(arm === 1'b1, "no rearm");
  endtask : wait_arm
  task automatic t_capture();
    run_n = 1'b0;
    rx_byte(b);
    chk(b === vta_pkg::REP_EVT_HDR, "header");
    rx_byte(b);
    rx_byte(b);
    chk(b === 8'h01, "run lo byte");
    run_n = 1'b1;
    hit(ev_n);
    chk(rc === 16'h0001 && ec === 16'h0000 && arm === 1'b0, "busy");
    wait_arm();
    hit(ev_n);
    chk(ec === 16'h0001, "event count");
    wait_arm();
    hit(run_n);
    chk(rc === 16'h0002 && ec === 16'h0000, "run clears");
    chk(cs === 1'b1 && evm > 27'h4, "event time shown");
    wait_arm();
  endtask : t_capture
  task automatic t_cmd(input logic [7:0] c, input logic r, input logic [9:0] x);
    gps_model_i.send_byte(c);
    cyc(8);
    chk(rm === r && xx === x, "command");
  endtask : t_cmd
  task automatic t_irig(input logic n, input logic [3:0] s, input logic [26:0] e);
    neg = n;
    sel = s;
    ims = 27'h0;
    ild = 1'b1;
    cyc(1);
    ild = 1'b0;
    cyc(1);
    show();
    chk(near(dms, e), "offset time");
  endtask : t_irig
  task automatic finish_test();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    {rst_n, run_n, ev_n, xh_n, neg, frame, ll_sw, ed_sw, irig, ild, vs, odd} = 12'h700;
    sel = 4'hC;
    {an, ub} = 2'h0;
    ims = 27'h0;
    cyc(8);
    rst_n = 1'b1;
    chk(sok === 1'b0 && arm === 1'b1 && xx === 10'h168 && yy === 9'h0F0, "reset");
    cyc(99);
    show();
    chk(near(dms, 27'h4), "free count");
    for (int i = 0; i < 3; i++) begin
      hit(xh_n);
      chk({xw, xb} === (i == 0 ? 2'b10 : i == 1 ? 2'b01 : 2'b00), "crosshair");
    end
    t_capture();
    t_cmd(8'h72, 1'b0, 10'h168);
    t_cmd(8'h52, 1'b1, 10'h168);
    t_cmd(8'h72, 1'b1, 10'h169);
    t_cmd(8'h57, 1'b0, 10'h169);
    irig = 1'b1;
    t_irig(1'b0, 4'h0, 12 * H);
    t_irig(1'b1, 4'hF, 3 * H);
    t_irig(1'b1, 4'h0, 12 * H);
    t_irig(1'b1, 4'hF, 3 * H);
    frame = 1'b1;
    odd = 1'b1;
    cyc(60);
    show();
    chk(near(dms, 3 * H), "frame skip");
    {frame, odd, irig, neg, sel} = 8'h1C;
    gps_model_i.send_str("$GPRMC,010203,A,,,,,,,150624*");
    gps_model_i.pulse(200);
    show();
    chk(sok === 1'b1 && near(dms, 27'h38D2E9) && date === 24'h150624, "gps");
    cyc(100);
    show();
    chk(near(dms, 27'h38D2EE), "dropout");
    {ll_sw, ed_sw, an, ub} = 4'hF;
    cyc(3);
    chk(ll === 1'b1 && ew === 1'b1, "switches");
    chk(tg === 1'b1 && tu === 1'b0 && bu === 1'b1, "annotation");
    finish_test();
  end
endmodule : video_time_event_annotator_tb
